// ===== lbs_map.vh
// lbs_map.vh: framing bytes, reply fields, status codes, register map
// assumes it is included by the lock-bit set handler only, once per unit
`ifndef LBS_MAP_VH
`define LBS_MAP_VH

// ----------------------------------------------------------------
// command framing
// ----------------------------------------------------------------
`define LBS_SOH 8'h01
`define LBS_ETX 8'h03
`define LBS_CMD_SET 8'h4A
`define LBS_CMD_READ 8'h4B
`define LBS_LEN_SET 16'h0013
`define LBS_LEN_READ 16'h0001
`define LBS_LEN_ZERO 16'h0000
`define LBS_LEN_ONE 16'h0001

// ----------------------------------------------------------------
// reply packet
// ----------------------------------------------------------------
`define LBS_SOD 8'h81
`define LBS_RLEN_H 8'h00
`define LBS_RLEN_L 8'h0A
`define LBS_RES_OK 8'h4A
`define LBS_RES_ERR 8'hCA
`define LBS_UNUSED 32'h0FFFFFFF
`define LBS_RIDX_LAST 4'hE
`define LBS_RIDX_SUM 4'hD
`define LBS_RIDX_FIRST_SUM 4'h1

// ----------------------------------------------------------------
// status codes (only OK has a fixed value; the rest are local)
// ----------------------------------------------------------------
`define LBS_ST_OK 8'h00
`define LBS_ST_PACKET 8'h01
`define LBS_ST_CHECKSUM 8'h02
`define LBS_ST_ACCEPT 8'h03
`define LBS_ST_SECURE 8'h04
`define LBS_ST_FLASH 8'h05

// ----------------------------------------------------------------
// lock data masks and authentication levels
// ----------------------------------------------------------------
`define LBS_MASK_FULL 8'hFF
`define LBS_MASK_LAST 8'h3F
`define LBS_RSV_LAST 8'hC0
`define LBS_AUTH_ZERO 2'h0
`define LBS_AUTH_ONE 2'h1

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define LBS_REG_CTRL 4'h0
`define LBS_REG_STAT 4'h4
`define LBS_REG_COUNT 4'h8
`define LBS_CTRL_RST 1'b1

`endif

// ===== lbs_lock_set.v
// lbs_lock_set.v: boot-link handler for the lock-bit set command
// assumes byte streams synchronous to clk_sys and a flash sequencer
// that answers each program request with one done pulse
//
// Operation
// RULE1 - set packet: SOH, 00h, 13h, 4Ah, data, check, ETX
// RULE2 - data bit 0 locks, bit 1 leaves open
// RULE3 - bytes stored upward in arrival order
// RULE4 - last byte programs only bits five to zero
// RULE5 - success reply 81h, 0Ah, 4Ah, status 00h
// RULE6 - failure reply 81h, 0Ah, CAh, status fields
// RULE7 - discard bytes until a start byte arrives
// RULE8 - bad terminator gives packet error
// RULE9 - bad check byte gives checksum error
// RULE10 - bad length fields give packet error
// RULE11 - any check error: no write, back idle
// RULE12 - lifecycle state refusal gives acceptance error
// RULE13 - auth levels one or zero give secure error
// RULE14 - sequencer error gives flash access error report
// RULE15 - clean programming sends OK, back idle
// RULE16 - report only the highest priority error
// RULE17 - non-flash errors fill detail and address unused
// RULE18 - cleared lock bits stay cleared, still OK
// RULE19 - read request: SOH, 00h, 01h, 4Bh, check, ETX
// RULE20 - bytes from length to check sum zero
// RULE21 - host awaits reply before next command
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`default_nettype none

`include "lbs_map.vh"

module lbs_lock_set #(
   parameter [4:0] LOCK_BYTES = 5'd18,
   parameter [15:0] FMT_MAX_LEN = 16'h0400,
   parameter [31:0] LOCK_BASE = 32'h27030380
) (
   input wire clk_sys,
   input wire arst_n,
   input wire rxValid,
   input wire [7:0] rxData,
   output wire rxReady,
   output reg txValid,
   output reg [7:0] txData,
   input wire txReady,
   input wire lcPermit,
   input wire [1:0] authLevel,
   output reg flashReq,
   output reg [31:0] flashAddr,
   output reg [7:0] flashData,
   output reg [7:0] flashMask,
   input wire flashDone,
   input wire flashErr,
   input wire [31:0] flashStatus,
   input wire [31:0] flashFailAddr,
   output reg readReq,
   output reg readErr,
   output reg [7:0] readErrCode,
   input wire [3:0] regAddr,
   input wire [31:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdata
);

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam [3:0] S_SOH = 4'h0;
   localparam [3:0] S_LNH = 4'h1;
   localparam [3:0] S_LNL = 4'h2;
   localparam [3:0] S_BODY = 4'h3;
   localparam [3:0] S_SUM = 4'h4;
   localparam [3:0] S_ETX = 4'h5;
   localparam [3:0] S_PROG = 4'h6;
   localparam [3:0] S_REPLY = 4'h7;

   reg [3:0] state;
   reg [15:0] lenRx;
   reg [15:0] bodyCnt;
   reg [7:0] cmdByte;
   reg [7:0] sumAcc;
   reg [7:0] lockBuf [0:31];
   reg [4:0] progIdx;
   reg [7:0] resCode;
   reg [7:0] stsCode;
   reg [31:0] stsDetail;
   reg [31:0] failAddr;
   reg [3:0] txIdx;
   reg [7:0] txSum;
   reg enable;
   reg [7:0] lastStatus;
   reg [15:0] okCount;

   wire rxTake = rxValid && rxReady;
   wire [15:0] dIdx = bodyCnt - `LBS_LEN_ONE;
   wire [15:0] lastBody = lenRx - `LBS_LEN_ONE;
   wire [7:0] sumNext = sumAcc + rxData;

   // bytes are accepted only while a frame is being collected
   assign rxReady = enable && (state <= S_ETX);

   // ----------------------------------------------------------------
   // reply byte selection
   // ----------------------------------------------------------------
   // multi-byte fields go out most significant byte first
   function [7:0] replyByte;
      input [3:0] idx;
      input [7:0] res;
      input [7:0] sts;
      input [31:0] det;
      input [31:0] adr;
      input [7:0] sum;
      begin
         case (idx)
            4'h0: replyByte = `LBS_SOD;
            4'h1: replyByte = `LBS_RLEN_H;
            4'h2: replyByte = `LBS_RLEN_L;
            4'h3: replyByte = res;
            4'h4: replyByte = sts;
            4'h5: replyByte = det[31:24];
            4'h6: replyByte = det[23:16];
            4'h7: replyByte = det[15:8];
            4'h8: replyByte = det[7:0];
            4'h9: replyByte = adr[31:24];
            4'hA: replyByte = adr[23:16];
            4'hB: replyByte = adr[15:8];
            4'hC: replyByte = adr[7:0];
            4'hD: replyByte = 8'h00 - sum;
            default: replyByte = `LBS_ETX;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // frame checks, evaluated on the terminator byte
   // ----------------------------------------------------------------
   reg [7:0] frameErr;
   reg cmdLenBad;

   // checks in descending priority; first failing one wins
   always @*
   begin
      cmdLenBad = 1'b0;
      if (cmdByte == `LBS_CMD_SET)
         cmdLenBad = (lenRx != `LBS_LEN_SET); // RULE1
      else if (cmdByte == `LBS_CMD_READ)
         cmdLenBad = (lenRx != `LBS_LEN_READ); // RULE19
      frameErr = `LBS_ST_OK;
      if (rxData != `LBS_ETX)
         frameErr = `LBS_ST_PACKET; // RULE8 RULE16
      else if (sumAcc != 8'h00)
         frameErr = `LBS_ST_CHECKSUM; // RULE9 RULE20
      else if ((lenRx == `LBS_LEN_ZERO) || (lenRx > FMT_MAX_LEN))
         frameErr = `LBS_ST_PACKET; // RULE10
      else if (cmdLenBad)
         frameErr = `LBS_ST_PACKET; // RULE10
      else if (cmdByte == `LBS_CMD_SET && !lcPermit)
         frameErr = `LBS_ST_ACCEPT; // RULE12
      else if (cmdByte == `LBS_CMD_SET &&
               (authLevel == `LBS_AUTH_ONE || authLevel == `LBS_AUTH_ZERO))
         frameErr = `LBS_ST_SECURE; // RULE13
   end

   // ----------------------------------------------------------------
   // receive, program and reply sequencer
   // ----------------------------------------------------------------
   // one command at a time: the host waits for the reply, so no
   // buffering of a second packet is needed
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= S_SOH;
         lenRx <= 16'h0000;
         bodyCnt <= 16'h0000;
         cmdByte <= 8'h00;
         sumAcc <= 8'h00;
         progIdx <= 5'h00;
         resCode <= `LBS_RES_OK;
         stsCode <= `LBS_ST_OK;
         stsDetail <= `LBS_UNUSED;
         failAddr <= `LBS_UNUSED;
         txIdx <= 4'h0;
         txSum <= 8'h00;
         txValid <= 1'b0;
         txData <= 8'h00;
         flashReq <= 1'b0;
         flashAddr <= 32'h00000000;
         flashData <= 8'h00;
         flashMask <= 8'h00;
         readReq <= 1'b0;
         readErr <= 1'b0;
         readErrCode <= 8'h00;
         lastStatus <= `LBS_ST_OK;
         okCount <= 16'h0000;
      end
      else
      begin
         readReq <= 1'b0;
         readErr <= 1'b0;
         case (state)
            S_SOH:
            begin
               // anything but a start byte is dropped
               if (rxTake && rxData == `LBS_SOH) // RULE7
               begin
                  sumAcc <= 8'h00;
                  cmdByte <= 8'h00;
                  state <= S_LNH;
               end
            end
            S_LNH:
            begin
               if (rxTake)
               begin
                  lenRx[15:8] <= rxData;
                  sumAcc <= sumNext;
                  state <= S_LNL;
               end
            end
            S_LNL:
            begin
               if (rxTake)
               begin
                  lenRx[7:0] <= rxData;
                  sumAcc <= sumNext;
                  bodyCnt <= 16'h0000;
                  // an empty body goes straight to the check byte
                  if ({lenRx[15:8], rxData} == `LBS_LEN_ZERO)
                     state <= S_SUM;
                  else
                     state <= S_BODY;
               end
            end
            S_BODY:
            begin
               if (rxTake)
               begin
                  sumAcc <= sumNext;
                  bodyCnt <= bodyCnt + 16'h0001;
                  if (bodyCnt == 16'h0000)
                     cmdByte <= rxData;
                  if (bodyCnt == lastBody)
                     state <= S_SUM;
               end
            end
            S_SUM:
            begin
               if (rxTake)
               begin
                  sumAcc <= sumNext; // RULE20
                  state <= S_ETX;
               end
            end
            S_ETX:
            begin
               if (rxTake)
               begin
                  if (cmdByte == `LBS_CMD_READ && !cmdLenBad)
                  begin
                     // read reply is produced elsewhere
                     readReq <= (frameErr == `LBS_ST_OK); // RULE19
                     readErr <= (frameErr != `LBS_ST_OK);
                     readErrCode <= frameErr;
                     state <= S_SOH;
                  end
                  else if (cmdByte == `LBS_CMD_SET || frameErr != `LBS_ST_OK)
                  begin
                     stsDetail <= `LBS_UNUSED; // RULE17
                     failAddr <= `LBS_UNUSED; // RULE17
                     if (frameErr == `LBS_ST_OK)
                     begin
                        progIdx <= 5'h00;
                        state <= S_PROG;
                     end
                     else
                     begin
                        // nothing is written on a refused packet
                        resCode <= `LBS_RES_ERR; // RULE6 RULE11
                        stsCode <= frameErr;
                        state <= S_REPLY;
                     end
                  end
                  else
                     state <= S_SOH;
               end
            end
            S_PROG:
            begin
               if (!flashReq)
               begin
                  // a 1 bit is left unprogrammed, so a lock already at 0
                  // simply stays at 0 and the byte still counts as done
                  flashReq <= 1'b1;
                  flashAddr <= LOCK_BASE + {27'h0000000, progIdx}; // RULE3
                  if (progIdx == LOCK_BYTES - 5'h01)
                  begin
                     flashData <= lockBuf[progIdx] | `LBS_RSV_LAST; // RULE4
                     flashMask <= `LBS_MASK_LAST; // RULE4
                  end
                  else
                  begin
                     flashData <= lockBuf[progIdx]; // RULE2 RULE18
                     flashMask <= `LBS_MASK_FULL;
                  end
               end
               else if (flashDone)
               begin
                  flashReq <= 1'b0;
                  if (flashErr)
                  begin
                     // remaining bytes are skipped; lock area undefined
                     resCode <= `LBS_RES_ERR; // RULE14
                     stsCode <= `LBS_ST_FLASH; // RULE14 RULE16
                     stsDetail <= flashStatus; // RULE14
                     failAddr <= flashFailAddr; // RULE14
                     state <= S_REPLY;
                  end
                  else if (progIdx == LOCK_BYTES - 5'h01)
                  begin
                     resCode <= `LBS_RES_OK; // RULE5 RULE15
                     stsCode <= `LBS_ST_OK; // RULE5
                     okCount <= okCount + 16'h0001;
                     state <= S_REPLY;
                  end
                  else
                     progIdx <= progIdx + 5'h01;
               end
            end
            S_REPLY:
            begin
               if (!txValid)
               begin
                  txIdx <= 4'h0;
                  txSum <= 8'h00;
                  txValid <= 1'b1;
                  txData <= `LBS_SOD; // RULE5 RULE6
                  lastStatus <= stsCode;
               end
               else if (txReady)
               begin
                  if (txIdx >= `LBS_RIDX_FIRST_SUM && txIdx < `LBS_RIDX_SUM)
                     txSum <= txSum + txData;
                  if (txIdx == `LBS_RIDX_LAST)
                  begin
                     txValid <= 1'b0;
                     state <= S_SOH; // RULE11 RULE15
                  end
                  else
                  begin
                     txIdx <= txIdx + 4'h1;
                     txData <= replyByte(txIdx + 4'h1, resCode, stsCode,
                        stsDetail, failAddr, txSum + txData);
                  end
               end
            end
            default:
               state <= S_SOH;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // lock data capture
   // ----------------------------------------------------------------
   // only the set command fills the buffer; no reset needed since it
   // is rewritten in full before every programming run
   always @(posedge clk_sys)
   begin
      if (state == S_BODY && rxTake && cmdByte == `LBS_CMD_SET &&
          bodyCnt != 16'h0000 && dIdx < {11'h000, LOCK_BYTES})
         lockBuf[dIdx[4:0]] <= rxData; // RULE3
   end

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   // enable gates the receiver; disabling mid-frame only stalls it
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         enable <= `LBS_CTRL_RST;
      else if (regWr && regAddr == `LBS_REG_CTRL)
         enable <= regWdata[0];
   end

   // read data stand one cycle after the strobe; unmapped reads 0
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         regRdata <= 32'h00000000;
      else if (regRd)
      begin
         if (regAddr == `LBS_REG_CTRL)
            regRdata <= {31'h00000000, enable};
         else if (regAddr == `LBS_REG_STAT)
            regRdata <= {23'h000000, (state != S_SOH), lastStatus};
         else if (regAddr == `LBS_REG_COUNT)
            regRdata <= {16'h0000, okCount};
         else
            regRdata <= 32'h00000000;
      end
      else
         regRdata <= 32'h00000000;
   end

endmodule

`default_nettype wire

// ===== end_marker_unused.v
`default_nettype none
`default_nettype wire

// ===== lbs_checker_sva.sv
// lbs_checker_sva.sv: port checker for the lock-bit set handler
// assumes it is bound onto lbs_lock_set and sees only its ports
`default_nettype none
module lbs_checker #(
   parameter [4:0] LOCK_BYTES = 5'd18,
   parameter [31:0] LOCK_BASE = 32'h27030380
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic rxReady,
   input wire logic txValid,
   input wire logic [7:0] txData,
   input wire logic txReady,
   input wire logic flashReq,
   input wire logic [31:0] flashAddr,
   input wire logic [7:0] flashData,
   input wire logic [7:0] flashMask,
   input wire logic flashDone,
   input wire logic flashErr
);
   wire logic [31:0] lastAddr = LOCK_BASE + {27'h0, LOCK_BYTES} - 32'h1;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------
   // lock area programming
   // ----------------------------------------
   // a request must not move under the sequencer's feet
   req_hold_a:
      assert property (flashReq && !flashDone |=> flashReq && $stable({flashAddr, flashData}))
      else $error("program request changed before done");
   // bytes go upward, one idle cycle between them
   next_byte_a:
      assert property (flashDone && !flashErr && flashReq && flashAddr != lastAddr
         |=> !flashReq ##1 (flashReq && flashAddr == $past(flashAddr, 2) + 32'h1))
      else $error("next lock byte not at the next location");
   addr_range_a:
      assert property (flashReq |-> flashAddr - LOCK_BASE < {27'h0, LOCK_BYTES})
      else $error("program address outside lock area");
   // reserved top bits of the final byte are never programmed
   last_mask_a:
      assert property (flashReq && flashAddr == lastAddr
         |-> flashMask == 8'h3F && flashData[7:6] == 2'b11)
      else $error("final byte programs reserved bits");
   full_mask_a:
      assert property (flashReq && flashAddr != lastAddr |-> flashMask == 8'hFF)
      else $error("ordinary byte not fully masked in");
   // ----------------------------------------
   // reply
   // ----------------------------------------
   // an error or the final byte ends programming and opens the reply
   prog_end_a:
      assert property (flashDone && (flashErr || flashAddr == lastAddr)
         |-> ##2 txValid && txData == 8'h81 && !flashReq)
      else $error("reply not started after programming ended");
   sod_first_a:
      assert property ($rose(txValid) |-> txData == 8'h81)
      else $error("reply does not open with the start marker");
   tx_hold_a:
      assert property (txValid && !txReady |=> txValid && $stable(txData))
      else $error("reply byte dropped while stalled");
   // the link stays shut while a command is being served
   busy_rx_a:
      assert property (txValid || flashReq |-> !rxReady && !(txValid && flashReq))
      else $error("receiver open or writing during reply");
endmodule
bind lbs_lock_set lbs_checker #(.LOCK_BYTES(LOCK_BYTES), .LOCK_BASE(LOCK_BASE)) chk (
   .clk_sys(clk_sys), .arst_n(arst_n), .rxReady(rxReady), .txValid(txValid),
   .txData(txData), .txReady(txReady), .flashReq(flashReq), .flashAddr(flashAddr),
   .flashData(flashData), .flashMask(flashMask), .flashDone(flashDone),
   .flashErr(flashErr));
`default_nettype wire

// ===== lbs_flash_model.sv
// lbs_flash_model.sv: behavioural flash sequencer holding the lock area
// assumes one program request at a time, held until done
`default_nettype none
module lbs_flash_model #(
   parameter [31:0] LOCK_BASE = 32'h27030380,
   parameter [31:0] ERR_STAT = 32'h00C0FFEE
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic flashReq,
   input wire logic [31:0] flashAddr,
   input wire logic [7:0] flashData,
   input wire logic [7:0] flashMask,
   input wire logic [4:0] errIdx,
   input wire logic [1:0] slow,
   output logic flashDone,
   output logic flashErr,
   output logic [31:0] flashStatus,
   output logic [31:0] flashFailAddr
);
   logic [7:0] mem [0:31];
   logic [1:0] cnt;
   logic [31:0] cyc;
   wire logic [4:0] idx = 5'(flashAddr - LOCK_BASE);
   // status lines carry noise except in the done cycle
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < 32; i++) mem[i] <= 8'hFF;
         cnt <= 2'h0;
         cyc <= 32'h0;
         flashDone <= 1'b0;
         flashErr <= 1'b0;
         flashStatus <= 32'h0;
         flashFailAddr <= 32'h0;
      end
      else
      begin
         cyc <= cyc + 32'h1;
         flashDone <= 1'b0;
         flashErr <= cyc[0];
         flashStatus <= ~cyc;
         flashFailAddr <= cyc;
         if (flashReq && !flashDone && cnt < slow) cnt <= cnt + 2'h1;
         else if (flashReq && !flashDone)
         begin
            cnt <= 2'h0;
            flashDone <= 1'b1;
            flashErr <= idx == errIdx;
            flashStatus <= ERR_STAT;
            flashFailAddr <= flashAddr;
            // zero bits lock; a cleared bit never returns to one
            if (idx != errIdx) mem[idx] <= mem[idx] & (flashData | ~flashMask);
         end
      end
   end
endmodule
`default_nettype wire

// ===== lbs_lock_set_tb_top.sv
// lbs_lock_set_tb_top.sv: self-checking bench for the lock-bit set handler
// assumes the flash model as sequencer and the bench as boot host
`default_nettype none
module lbs_lock_set_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [31:0] BASE = 32'h27030380;
   localparam [31:0] ESTAT = 32'h00C0FFEE;
   localparam [31:0] NONE = 32'h0FFFFFFF;
   logic clk_sys = 1'b0, arst_n = 1'b0, rxValid = 1'b0, txReady = 1'b0, lcPermit = 1'b1;
   logic regWr = 1'b0, regRd = 1'b0;
   logic [7:0] rxData = 8'h00;
   logic [1:0] authLevel = 2'h2, slow = 2'h0;
   logic [4:0] errIdx = 5'h1F;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   wire logic rxReady, txValid, flashReq, flashDone, flashErr, readReq, readErr;
   wire logic [7:0] txData, flashData, flashMask, readErrCode;
   wire logic [31:0] flashAddr, flashStatus, flashFailAddr, regRdata;
   integer fails = 0, checks = 0, seed = 32'h4613f9dc, i, t;
   logic [8:0] expQ [$];
   logic [7:0] lk [0:17];
   logic [7:0] gold [0:17];
   logic [47:0] e;
   // len, check flip, terminator, lifecycle, auth level, expected status
   logic [47:0] errTab [0:8] = '{48'h0013_0002_1201, 48'h0013_5A03_1202, 48'h0013_5A02_0001,
      48'h0014_0003_1201, 48'h0001_0003_1201, 48'h0013_0003_0003, 48'h0013_0003_1004,
      48'h0013_0003_1104, 48'h0013_5A03_0202};
   lbs_lock_set DUT (.clk_sys(clk_sys), .arst_n(arst_n), .rxValid(rxValid), .rxData(rxData),
      .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady),
      .lcPermit(lcPermit), .authLevel(authLevel), .flashReq(flashReq), .flashAddr(flashAddr),
      .flashData(flashData), .flashMask(flashMask), .flashDone(flashDone), .flashErr(flashErr),
      .flashStatus(flashStatus), .flashFailAddr(flashFailAddr), .readReq(readReq),
      .readErr(readErr), .readErrCode(readErrCode), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
   lbs_flash_model #(.LOCK_BASE(BASE), .ERR_STAT(ESTAT)) flashModel (.clk_sys(clk_sys),
      .arst_n(arst_n), .flashReq(flashReq), .flashAddr(flashAddr), .flashData(flashData),
      .flashMask(flashMask), .errIdx(errIdx), .slow(slow), .flashDone(flashDone),
      .flashErr(flashErr), .flashStatus(flashStatus), .flashFailAddr(flashFailAddr));
   initial forever #20 clk_sys = ~clk_sys;
   // the reply consumer stalls at random
   always @(posedge clk_sys) txReady <= ($random(seed) & 3) != 0;
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic popCheck(input logic [8:0] got);
      if (expQ.size() == 0) check(got, 32'h1FF);
      else check(got, expQ.pop_front());
   endtask
   // every reply byte and read notice is matched against the oldest note
   always @(posedge clk_sys)
   begin
      if (txValid === 1'b1 && txReady === 1'b1) popCheck({1'b0, txData});
      if (readReq !== readErr) popCheck({readReq, readErrCode});
   end
   // one byte held until the receiver takes it, then maybe a gap
   task automatic sendByte(input logic [7:0] b);
      integer n;
      rxValid <= 1'b1;
      rxData <= b;
      for (n = 0; n < 200; n++)
      begin
         @(posedge clk_sys);
         if (rxReady === 1'b1) break;
      end
      if (n == 200)
      begin
         fails++;
         conclude();
      end
      if ($random(seed) % 3 == 0)
      begin
         rxValid <= 1'b0;
         @(posedge clk_sys);
      end
   endtask
   task automatic sendFrame(input logic [15:0] len, input logic [7:0] cmd,
      input logic [7:0] sumX, input logic [7:0] etx);
      logic [7:0] s;
      s = len[15:8] + len[7:0] + cmd;
      sendByte(8'h01);
      sendByte(len[15:8]);
      sendByte(len[7:0]);
      sendByte(cmd);
      for (int k = 0; k < len - 1; k++)
      begin
         sendByte(lk[k % 18]);
         s += lk[k % 18];
      end
      sendByte(-s ^ sumX);
      sendByte(etx);
      rxValid <= 1'b0;
   endtask
   task automatic expReply(input logic [7:0] res, input logic [7:0] sts,
      input logic [31:0] det, input logic [31:0] adr);
      logic [103:0] v;
      logic [7:0] s;
      v = {8'h81, 8'h00, 8'h0A, res, sts, det, adr};
      s = 8'h00;
      for (int k = 12; k >= 0; k--)
      begin
         expQ.push_back({1'b0, v[k * 8 +: 8]});
         if (k < 12) s += v[k * 8 +: 8];
      end
      expQ.push_back({1'b0, 8'(-s)});
      expQ.push_back(9'h003);
   endtask
   // bounded wait until every noted result has been seen
   task automatic drain();
      integer n;
      for (n = 0; n < 3000 && expQ.size() != 0; n++) @(posedge clk_sys);
      if (expQ.size() != 0)
      begin
         fails++;
         conclude();
      end
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic newData(input logic allOnes);
      for (int k = 0; k < 18; k++) lk[k] = allOnes ? 8'hFF : 8'($random(seed));
   endtask
   task automatic verifyMem(input logic update);
      for (int k = 0; k < 18; k++)
      begin
         if (update) gold[k] &= lk[k] | (k == 17 ? 8'hC0 : 8'h00);
         check(flashModel.mem[k], gold[k]);
      end
   endtask
   task automatic regAccess(input logic wr, input logic [3:0] a, input logic [31:0] v);
      regAddr <= a;
      regWdata <= v;
      regWr <= wr;
      regRd <= !wr;
      @(posedge clk_sys);
      regWr <= 1'b0;
      regRd <= 1'b0;
      @(posedge clk_sys);
      if (!wr) check(regRdata, v);
   endtask
   initial
   begin
      for (i = 0; i < 18; i++) gold[i] = 8'hFF;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      sendByte(8'h4A);
      sendByte(8'h03);
      for (t = 0; t < 2; t++)
      begin
         newData(t == 1);
         slow <= t ? 2'h0 : 2'h3;
         authLevel <= t ? 2'h3 : 2'h2;
         expReply(8'h4A, 8'h00, NONE, NONE);
         sendFrame(16'h0013, 8'h4A, 8'h00, 8'h03);
         drain();
         verifyMem(1'b1);
      end
      regAccess(1'b0, 4'h8, 32'h2);
      regAccess(1'b0, 4'h4, 32'h0);
      regAccess(1'b0, 4'hC, 32'h0);
      $display("test good set commands done");
      for (t = 0; t < 9; t++)
      begin
         e = errTab[t];
         newData(1'b0);
         lcPermit <= e[12];
         authLevel <= e[9:8];
         expReply(8'hCA, e[7:0], NONE, NONE);
         sendFrame(e[47:32], 8'h4A, e[31:24], e[23:16]);
         drain();
         verifyMem(1'b0);
      end
      lcPermit <= 1'b1;
      authLevel <= 2'h2;
      $display("test refused commands done");
      newData(1'b0);
      errIdx <= 5'h5;
      slow <= 2'h1;
      expReply(8'hCA, 8'h05, ESTAT, BASE + 32'h5);
      sendFrame(16'h0013, 8'h4A, 8'h00, 8'h03);
      drain();
      errIdx <= 5'h1F;
      $display("test flash error done");
      expQ.push_back(9'h100);
      expQ.push_back(9'h002);
      sendFrame(16'h0001, 8'h4B, 8'h00, 8'h03);
      sendFrame(16'h0001, 8'h4B, 8'h5A, 8'h03);
      drain();
      regAccess(1'b1, 4'h0, 32'h0);
      regAccess(1'b0, 4'h0, 32'h0);
      check(rxReady, 32'h0);
      regAccess(1'b1, 4'h0, 32'h1);
      check(rxReady, 32'h1);
      $display("test read request and registers done");
      conclude();
   end
endmodule
`default_nettype wire
